// File: logic/frame_timer.sv
`timescale 1ns/1ps
module frame_timer
#(
   parameter int UFRAME_CYCLES = split_tt_pkg::UFRAME_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        uframe_tick,
   output logic             uframe_start,
   output logic [2:0]       uframe_num,
   output logic             frame_start,
   output logic [15:0]      cycles_left
);
   logic [2:0]  next_uframe_num;
   logic [15:0] next_cycles_left;
   logic        next_uframe_start;
   logic        next_frame_start;

   always_comb
   begin
      next_uframe_num   = uframe_num;
      next_uframe_start = 1'b0;
      next_frame_start  = 1'b0;
      next_cycles_left  = (cycles_left != 16'h0000) ? cycles_left - 16'h0001 : 16'h0000;
      if (uframe_tick)
      begin
         next_uframe_start = 1'b1;
         next_uframe_num   = uframe_num + 3'h1;
         // frame boundary aligned to microframe zero, nothing else carried
         if (uframe_num == 3'(split_tt_pkg::UFRAMES_PER_FRAME - 1))
         begin
            next_frame_start = 1'b1;
            next_cycles_left = 16'(split_tt_pkg::FRAME_CYCLES);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         uframe_num   <= 3'h7;
         uframe_start <= 1'b0;
         frame_start  <= 1'b0;
         cycles_left  <= 16'h0000;
      end
      else
      begin
         uframe_num   <= next_uframe_num;
         uframe_start <= next_uframe_start;
         frame_start  <= next_frame_start;
         cycles_left  <= next_cycles_left;
      end
   end
endmodule // frame_timer

// File: logic/split_translator_nonperiodic_sched.sv
`timescale 1ns/1ps
module split_translator_nonperiodic_sched
#(
   parameter int NUM_BUFS = split_tt_pkg::NUM_BUFS,
   parameter int MAXLEN_W = 11
)
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   // high-speed microframe timer
   input  wire logic                uframe_tick,
   // start-split from host
   input  wire logic                ss_valid,
   input  wire logic [6:0]          ss_addr,
   input  wire logic [3:0]          ss_endp,
   input  wire logic                ss_dir_in,
   input  wire logic                ss_control,
   input  wire logic                ss_low_speed,
   input  wire logic [MAXLEN_W-1:0] ss_len,
   output logic                     ss_reply_valid,
   output split_tt_pkg::reply_t     ss_reply,
   // complete-split from host
   input  wire logic                cs_valid,
   input  wire logic [6:0]          cs_addr,
   input  wire logic [3:0]          cs_endp,
   input  wire logic                cs_dir_in,
   input  wire logic                cs_control,
   output logic                     cs_reply_valid,
   output split_tt_pkg::reply_t     cs_reply,
   output split_tt_pkg::result_t    cs_result,
   // periodic queue status
   input  wire logic                per_waiting,
   output logic                     per_take,
   output logic                     per_advance,
   // downstream handler
   output logic                     ds_start,
   output logic [$clog2(NUM_BUFS)-1:0] ds_buf,
   output logic [6:0]               ds_addr,
   output logic [3:0]               ds_endp,
   output logic                     ds_dir_in,
   output logic                     ds_preamble,
   input  wire logic                ds_done,
   input  wire logic                ds_got_nak,
   input  wire logic                ds_got_ack,
   input  wire logic                ds_got_stall,
   input  wire logic                ds_got_data,
   input  wire logic [split_tt_pkg::ERR_W-1:0] ds_err,
   output logic [NUM_BUFS-1:0]      buf_pending,
   output logic                     frame_start
);
   localparam int IW = $clog2(NUM_BUFS);

   ////////////////////////////////////////////////////////////////////
   logic        uframe_start;
   logic [2:0]  uframe_num;
   logic [15:0] cycles_left;

   frame_timer u_timer
   (
      .clk          (clk),
      .rst_n        (rst_n),
      .uframe_tick  (uframe_tick),
      .uframe_start (uframe_start),
      .uframe_num   (uframe_num),
      .frame_start  (frame_start),
      .cycles_left  (cycles_left)
   );

   assign per_advance = uframe_start;

   ////////////////////////////////////////////////////////////////////
   // buffer table
   split_tt_pkg::buf_state_t st      [NUM_BUFS];
   split_tt_pkg::result_t    res     [NUM_BUFS];
   logic [6:0]               b_addr  [NUM_BUFS];
   logic [3:0]               b_endp  [NUM_BUFS];
   logic                     b_dir   [NUM_BUFS];
   logic                     b_ctl   [NUM_BUFS];
   logic                     b_ls    [NUM_BUFS];
   logic [MAXLEN_W-1:0]      b_len   [NUM_BUFS];
   split_tt_pkg::buf_state_t next_st [NUM_BUFS];
   split_tt_pkg::result_t    next_res[NUM_BUFS];
   logic                     busy;
   logic                     next_busy;
   logic [IW-1:0]            rr_last;
   logic [IW-1:0]            next_rr_last;
   logic [IW-1:0]            next_ds_buf;

   function automatic logic hit(input logic [6:0] ba, input logic [3:0] be, input logic bd,
                                input logic [6:0] a, input logic [3:0] e, input logic d,
                                input logic ctl);
      hit = (ba == a) && (be == e) && ((bd == d) || ctl);
   endfunction

   // worst-case duration, longer for low speed
   function automatic logic [31:0] est(input logic [MAXLEN_W-1:0] len, input logic ls);
      logic [31:0] bytes;
      bytes = 32'(len) + 32'(split_tt_pkg::OVERHEAD_BYTES);
      est = bytes * (ls ? 32'(split_tt_pkg::LS_CYC_PER_BYTE)
                        : 32'(split_tt_pkg::FS_CYC_PER_BYTE));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // start-split lookup: first match wins, else first old buffer
   logic          ss_match;
   logic          ss_old_hit;
   logic          ss_free;
   logic [IW-1:0] ss_idx;
   logic [IW-1:0] free_idx;

   always_comb
   begin
      ss_match = 1'b0;
      ss_old_hit = 1'b0;
      ss_free = 1'b0;
      ss_idx = '0;
      free_idx = '0;
      for (int i = 0; i < NUM_BUFS; i++)
      begin
         if (!ss_match && hit(b_addr[i], b_endp[i], b_dir[i], ss_addr, ss_endp, ss_dir_in,
                              ss_control) && st[i] != split_tt_pkg::ST_OLD)
         begin
            ss_match = 1'b1;
            ss_idx = IW'(i);
         end
         if (!ss_free && st[i] == split_tt_pkg::ST_OLD)
         begin
            ss_free = 1'b1;
            free_idx = IW'(i);
         end
      end
      ss_old_hit = ss_match;
   end

   // complete-split lookup
   logic          cs_hit;
   logic [IW-1:0] cs_idx;

   always_comb
   begin
      cs_hit = 1'b0;
      cs_idx = '0;
      for (int i = 0; i < NUM_BUFS; i++)
      begin
         if (!cs_hit && st[i] != split_tt_pkg::ST_OLD &&
             hit(b_addr[i], b_endp[i], b_dir[i], cs_addr, cs_endp, cs_dir_in, cs_control))
         begin
            cs_hit = 1'b1;
            cs_idx = IW'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // downstream pick: periodic first, then round robin over pending buffers
   logic          pick_ok;
   logic [IW-1:0] pick_idx;
   logic          idle_now;

   always_comb
   begin
      logic [IW-1:0] k;
      k = '0;
      pick_ok = 1'b0;
      pick_idx = '0;
      for (int j = 1; j <= NUM_BUFS; j++)
      begin
         k = IW'((32'(rr_last) + 32'(j)) % NUM_BUFS);
         // the buffer finishing this cycle still reads pending, never restart it
         if (!pick_ok && st[k] == split_tt_pkg::ST_PENDING &&
             !(busy && ds_done && k == ds_buf) &&
             est(b_len[k], b_ls[k]) <= 32'(cycles_left))
         begin
            pick_ok = 1'b1;
            pick_idx = k;
         end
      end
   end

   // done frees the handler the same cycle so bulk can run back to back
   assign idle_now = !busy || ds_done;
   assign per_take = idle_now && per_waiting;
   assign ds_start = idle_now && !per_waiting && pick_ok;

   always_comb
   begin
      split_tt_pkg::result_t r;
      r = split_tt_pkg::RES_NAK;
      next_busy = busy;
      next_rr_last = rr_last;
      next_ds_buf = ds_buf;
      for (int i = 0; i < NUM_BUFS; i++)
      begin
         next_st[i] = st[i];
         next_res[i] = res[i];
      end
      // downstream outcome stored in its own buffer
      if (ds_err != '0)
         r = split_tt_pkg::RES_TRANSERR;
      else if (ds_got_stall)
         r = split_tt_pkg::RES_STALL;
      else if (ds_got_ack)
         r = split_tt_pkg::RES_ACK;
      else if (ds_got_data)
         r = split_tt_pkg::RES_DATA;
      else if (ds_got_nak)
         r = split_tt_pkg::RES_NAK;
      else
         r = split_tt_pkg::RES_TRANSERR; // timeout
      if (busy && ds_done)
      begin
         next_busy = 1'b0;
         next_st[ds_buf] = split_tt_pkg::ST_READY;
         next_res[ds_buf] = r;
      end
      if (per_take)
         next_busy = 1'b0; // periodic handled by its own pipeline
      if (ds_start)
      begin
         next_busy = 1'b1;
         next_ds_buf = pick_idx;
         next_rr_last = pick_idx;
      end
      // complete-split on ready result returns buffer to old, result kept
      if (cs_valid && cs_hit && st[cs_idx] == split_tt_pkg::ST_READY &&
          !(busy && ds_done && ds_buf == cs_idx))
         next_st[cs_idx] = split_tt_pkg::ST_OLD;
      // new start-split claims a free buffer; retries and refusals touch nothing
      if (ss_valid && !ss_old_hit && ss_free)
         next_st[free_idx] = split_tt_pkg::ST_PENDING;
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         busy <= 1'b0;
         rr_last <= IW'(NUM_BUFS - 1);
         ds_buf <= '0;
         ss_reply_valid <= 1'b0;
         ss_reply <= split_tt_pkg::REP_NAK;
         cs_reply_valid <= 1'b0;
         cs_reply <= split_tt_pkg::REP_NAK;
         cs_result <= split_tt_pkg::RES_NAK;
         for (int i = 0; i < NUM_BUFS; i++)
         begin
            st[i] <= split_tt_pkg::ST_OLD;
            res[i] <= split_tt_pkg::RES_NAK;
            b_addr[i] <= 7'h00;
            b_endp[i] <= 4'h0;
            b_dir[i] <= 1'b0;
            b_ctl[i] <= 1'b0;
            b_ls[i] <= 1'b0;
            b_len[i] <= '0;
         end
      end
      else
      begin
         busy <= next_busy;
         rr_last <= next_rr_last;
         ds_buf <= next_ds_buf;
         for (int i = 0; i < NUM_BUFS; i++)
         begin
            st[i] <= next_st[i];
            res[i] <= next_res[i];
         end
         if (ss_valid && !ss_old_hit && ss_free)
         begin
            b_addr[free_idx] <= ss_addr;
            b_endp[free_idx] <= ss_endp;
            b_dir[free_idx] <= ss_dir_in;
            b_ctl[free_idx] <= ss_control;
            b_ls[free_idx] <= ss_low_speed;
            b_len[free_idx] <= ss_len;
         end
         ss_reply_valid <= ss_valid;
         // retry of held transaction is acked, no buffer means NAK
         ss_reply <= (ss_old_hit || ss_free) ? split_tt_pkg::REP_ACK
                                             : split_tt_pkg::REP_NAK;
         cs_reply_valid <= cs_valid;
         cs_result <= res[cs_idx];
         if (!cs_hit)
            cs_reply <= split_tt_pkg::REP_NAK;
         else if (st[cs_idx] == split_tt_pkg::ST_READY)
            cs_reply <= split_tt_pkg::REP_RESULT;
         else
            cs_reply <= split_tt_pkg::REP_NYET;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      ds_addr = b_addr[ds_buf];
      ds_endp = b_endp[ds_buf];
      ds_dir_in = b_dir[ds_buf];
      ds_preamble = b_ls[ds_buf];
      for (int i = 0; i < NUM_BUFS; i++)
         buf_pending[i] = (st[i] == split_tt_pkg::ST_PENDING);
   end
endmodule // split_translator_nonperiodic_sched

// File: logic/split_tt_pkg.sv
// What this block does
// - accept new bulk start-split only with free buffer, ack retries of held ones
// - refused start-splits answered NAK, host retries
// - issue from buffer, store outcome there
// - free buffer only on matching complete-split
// - periodic work first after each transaction
// - bulk only when periodic queue empty
// - bulk starts only if frame time suffices
// - pending bulk buffers served round robin
// - periodic pipeline advanced by microframe timer
// - frame start derived from eight microframes
// - no timing fields, frame aligns microframe zero
// - ready status qualified by downstream result
// - all listed faults map to trans_err
// - buffers start old, return old keeping result
// - unfinished downstream work holds pending
// - complete-split reply from buffer status
// - back-to-back bulk scheduling for full throughput
// - several endpoints tracked by buffer state
// - low speed differs by preamble and a longer time estimate
// - at least two bulk/control buffers
// - match address, endpoint, direction unless control
package split_tt_pkg;
   localparam int NUM_BUFS = 2;
   localparam int UFRAMES_PER_FRAME = 8;
   localparam int UFRAME_NS = 125000;
   localparam int CLK_NS = 20;
   localparam int UFRAME_CYCLES = UFRAME_NS / CLK_NS;
   localparam int FRAME_CYCLES = UFRAME_CYCLES * UFRAMES_PER_FRAME;
   // worst case bit times scaled to clock cycles: fs bit ~83ns, ls bit ~667ns
   localparam int FS_CYC_PER_BYTE = 34;
   localparam int LS_CYC_PER_BYTE = 267;
   localparam int OVERHEAD_BYTES = 16;

   typedef enum logic [1:0]
   {
      ST_OLD     = 2'b00,
      ST_PENDING = 2'b01,
      ST_READY   = 2'b10
   } buf_state_t;

   typedef enum logic [2:0]
   {
      RES_NAK      = 3'b000,
      RES_TRANSERR = 3'b001,
      RES_ACK      = 3'b010,
      RES_STALL    = 3'b011,
      RES_DATA     = 3'b100,
      RES_LASTDATA = 3'b101,
      RES_MOREDATA = 3'b110
   } result_t;

   typedef enum logic [1:0]
   {
      REP_NAK    = 2'b00,
      REP_ACK    = 2'b01,
      REP_NYET   = 2'b10,
      REP_RESULT = 2'b11
   } reply_t;

   // error causes, one bit each
   localparam int ERR_W = 8;
endpackage

// File: verification/ds_bus_model.sv
`timescale 1ns/1ps
module ds_bus_model
(
   input  wire logic       clk,
   input  wire logic       ds_start,
   input  wire logic [3:0] kind,
   output logic            ds_done,
   output logic            ds_got_nak,
   output logic            ds_got_ack,
   output logic            ds_got_stall,
   output logic            ds_got_data,
   output logic [7:0]      ds_err
);
   logic [7:0] cnt = 8'h00;
   logic [3:0] k = 4'h0;
   int         left = 0;
   initial ds_done = 1'b0;
   // outcome lines churn outside done so stale values never pass as results
   always @(posedge clk)
   begin
      cnt <= cnt + 8'h01;
      ds_done <= 1'b0;
      {ds_got_nak, ds_got_ack, ds_got_stall, ds_got_data} <= cnt[3:0];
      ds_err <= ~cnt;
      if (left > 0)
         left <= left - 1;
      if (ds_start === 1'b1)
      begin
         k <= kind;
         left <= 3 + 9 * int'(kind);
      end
      else if (left == 1)
      begin
         ds_done <= 1'b1;
         {ds_got_nak, ds_got_ack, ds_got_stall, ds_got_data} <= 4'h8 >> k;
         // kind 12 is a timeout: no outcome bit at all
         ds_err <= (k > 4'h3 && k < 4'hC) ? 8'h01 << (k - 4'h4) : 8'h00;
      end
   end
endmodule // ds_bus_model

// File: verification/split_translator_nonperiodic_sched_tb_top.sv
`timescale 1ns/1ps
module split_translator_nonperiodic_sched_tb_top;
   logic                         clk = 1'b0, rst_n = 1'b0, uframe_tick = 1'b0;
   logic                         ss_valid = 1'b0, ss_dir_in = 1'b0, ss_control = 1'b0;
   logic                         ss_low_speed = 1'b0, cs_valid = 1'b0, cs_dir_in = 1'b0;
   logic                         cs_control = 1'b0, per_waiting = 1'b0;
   logic [6:0]                   ss_addr = 7'h00, cs_addr = 7'h00, a, ds_addr;
   logic [10:0]                  ss_len = 11'h000;
   logic [3:0]                   kind = 4'h1, ds_endp, cs_endp = 4'h2;
   logic                         ss_reply_valid, cs_reply_valid, per_take, per_advance;
   logic                         ds_start, ds_dir_in, ds_preamble, ds_done, frame_start;
   logic                         ds_got_nak, ds_got_ack, ds_got_stall, ds_got_data;
   logic [0:0]                   ds_buf;
   logic [1:0]                   buf_pending;
   logic [7:0]                   ds_err;
   logic                         ds_seen = 1'b0, d, l;
   split_tt_pkg::reply_t         ss_reply, cs_reply;
   split_tt_pkg::result_t        cs_result;
   split_tt_pkg::result_t        res_tab [4] = '{split_tt_pkg::RES_NAK, split_tt_pkg::RES_ACK,
                                                 split_tt_pkg::RES_STALL, split_tt_pkg::RES_DATA};
   logic [7:0]                   q_ss [$], q_cs [$], q_ds [$], q_dd [$];
   int                           n_fail = 0, checked = 0, cyc = 0;
   always #10 clk = ~clk;
   split_translator_nonperiodic_sched u_dut (.clk(clk), .rst_n(rst_n),
      .uframe_tick(uframe_tick), .ss_valid(ss_valid), .ss_addr(ss_addr), .ss_endp(4'h2),
      .ss_dir_in(ss_dir_in), .ss_control(ss_control), .ss_low_speed(ss_low_speed),
      .ss_len(ss_len), .ss_reply_valid(ss_reply_valid), .ss_reply(ss_reply),
      .cs_valid(cs_valid), .cs_addr(cs_addr), .cs_endp(cs_endp), .cs_dir_in(cs_dir_in),
      .cs_control(cs_control), .cs_reply_valid(cs_reply_valid), .cs_reply(cs_reply),
      .cs_result(cs_result), .per_waiting(per_waiting), .per_take(per_take),
      .per_advance(per_advance), .ds_start(ds_start), .ds_buf(ds_buf), .ds_addr(ds_addr),
      .ds_endp(ds_endp), .ds_dir_in(ds_dir_in), .ds_preamble(ds_preamble),
      .ds_done(ds_done), .ds_got_nak(ds_got_nak), .ds_got_ack(ds_got_ack),
      .ds_got_stall(ds_got_stall), .ds_got_data(ds_got_data), .ds_err(ds_err),
      .buf_pending(buf_pending), .frame_start(frame_start));
   ds_bus_model u_ds (.clk(clk), .ds_start(ds_start), .kind(kind), .ds_done(ds_done),
      .ds_got_nak(ds_got_nak), .ds_got_ack(ds_got_ack), .ds_got_stall(ds_got_stall),
      .ds_got_data(ds_got_data), .ds_err(ds_err));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic ss(input logic [6:0] ad, input logic dr, c, s, input logic [10:0] n,
                     input split_tt_pkg::reply_t r);
      @(negedge clk);
      {ss_addr, ss_dir_in, ss_control, ss_low_speed, ss_len} = {ad, dr, c, s, n};
      ss_valid = 1'b1;
      q_ss.push_back({6'h00, r});
      @(negedge clk);
      ss_valid = 1'b0;
   endtask
   task automatic cs(input logic [6:0] ad, input logic dr, c, input logic [4:0] r);
      @(negedge clk);
      {cs_addr, cs_dir_in, cs_control} = {ad, dr, c};
      cs_valid = 1'b1;
      q_cs.push_back({3'h0, r});
      @(negedge clk);
      cs_valid = 1'b0;
   endtask
   task automatic wait_for(input int which);
      int i;
      for (i = 0; i < 60000; i++)
      begin
         @(negedge clk);
         if ((which == 0 ? ds_done : frame_start) === 1'b1)
            return;
      end
      n_fail++;
      test_done();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // result watcher; the microframe timer and the run limit ride along
   always @(negedge clk)
   begin
      cyc++;
      uframe_tick <= (cyc % split_tt_pkg::UFRAME_CYCLES == 0);
      if (ss_reply_valid === 1'b1)
         check({6'h00, ss_reply}, q_ss.pop_front());
      if (cs_reply_valid === 1'b1)
         check({3'h0, cs_reply, cs_reply == split_tt_pkg::REP_RESULT ? cs_result
               : split_tt_pkg::RES_NAK}, q_cs.pop_front());
      if (ds_seen)
      begin
         check({ds_preamble, ds_addr}, q_ds.pop_front());
         check({3'h0, ds_dir_in, ds_endp}, q_dd.pop_front());
      end
      if (cyc > 99000)
      begin
         n_fail++;
         test_done();
      end
   end
   // start strobe is combinational, so take it where it has settled
   always @(posedge clk)
      ds_seen <= (ds_start === 1'b1);
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h6612));
      a = 7'($urandom_range(1, 100));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      per_waiting = 1'b1;
      ss(a, 1'b1, 1'b0, 1'b0, 11'h028, split_tt_pkg::REP_ACK);
      ss(a + 7'h01, 1'b1, 1'b0, 1'b0, 11'h010, split_tt_pkg::REP_ACK);
      ss(a + 7'h02, 1'b1, 1'b0, 1'b0, 11'h010, split_tt_pkg::REP_NAK);
      ss(a, 1'b1, 1'b0, 1'b0, 11'h028, split_tt_pkg::REP_ACK);
      ss(a, 1'b0, 1'b0, 1'b0, 11'h028, split_tt_pkg::REP_NAK);
      cs(a, 1'b1, 1'b0, {split_tt_pkg::REP_NYET, split_tt_pkg::RES_NAK});
      cs(a + 7'h02, 1'b1, 1'b0, {split_tt_pkg::REP_NAK, split_tt_pkg::RES_NAK});
      cs_endp = 4'h3;
      cs(a, 1'b1, 1'b0, {split_tt_pkg::REP_NAK, split_tt_pkg::RES_NAK});
      cs_endp = 4'h2;
      // bulk must hold until the first frame and while periodic work waits
      wait_for(1);
      repeat (20) @(negedge clk);
      q_ds.push_back({1'b0, a});
      q_ds.push_back({1'b0, a + 7'h01});
      q_dd.push_back(8'h12);
      q_dd.push_back(8'h12);
      per_waiting = 1'b0;
      wait_for(0);
      wait_for(0);
      cs(a, 1'b1, 1'b0, {split_tt_pkg::REP_RESULT, split_tt_pkg::RES_ACK});
      cs(a + 7'h01, 1'b1, 1'b0, {split_tt_pkg::REP_RESULT, split_tt_pkg::RES_ACK});
      for (int k = 0; k < 13; k++)
      begin
         kind = 4'(k);
         d = 1'($urandom);
         l = 1'(k);
         q_ds.push_back({l, a + 7'h02});
         q_dd.push_back({3'h0, d, 4'h2});
         ss(a + 7'h02, d, 1'b1, l, 11'($urandom_range(0, 31)), split_tt_pkg::REP_ACK);
         // let the bulk start first; on the last pass (k == 12) periodic work then queues up behind it
         @(negedge clk);
         per_waiting = (k == 12);
         wait_for(0);
         cs(a + 7'h02, ~d, 1'b1, {split_tt_pkg::REP_RESULT,
            k < 4 ? res_tab[k] : split_tt_pkg::RES_TRANSERR});
      end
      repeat (5) @(negedge clk);
      per_waiting = 1'b0;
      // a low-speed maximum packet can never fit the remaining frame
      ss(a + 7'h03, 1'b1, 1'b0, 1'b1, 11'h3FF, split_tt_pkg::REP_ACK);
      repeat (300) @(negedge clk);
      test_done();
   end
endmodule // split_translator_nonperiodic_sched_tb_top

// File: verification/split_tt_props.sv
`timescale 1ns/1ps
module split_tt_props
#(
   parameter int NUM_BUFS = 2
)
(
   input wire logic                        clk,
   input wire logic                        rst_n,
   input wire logic                        uframe_tick,
   input wire logic                        ss_valid,
   input wire logic                        ss_reply_valid,
   input wire split_tt_pkg::reply_t        ss_reply,
   input wire logic                        cs_valid,
   input wire logic                        cs_reply_valid,
   input wire split_tt_pkg::reply_t        cs_reply,
   input wire logic                        per_waiting,
   input wire logic                        per_take,
   input wire logic                        per_advance,
   input wire logic                        ds_start,
   input wire logic [$clog2(NUM_BUFS)-1:0] ds_buf,
   input wire logic                        ds_done,
   input wire logic [NUM_BUFS-1:0]         buf_pending,
   input wire logic                        frame_start
);
   logic [3:0] ticks;
   logic [3:0] next_ticks;
   logic       seen;
   logic       next_seen;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // ticks since the last frame start, to pin the eight-microframe frame
   always_comb
   begin
      next_ticks = frame_start ? 4'h0 : ticks + {3'h0, uframe_tick};
      next_seen = seen | frame_start;
   end
   always_ff @(posedge clk)
   begin
      ticks <= rst_n ? next_ticks : 4'h7; // timer wakes on the last microframe
      seen <= rst_n ? next_seen : 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   chk_ss_answer: assert property (ss_valid |=> ss_reply_valid)
      else $error("start-split not answered next cycle");
   chk_ss_spurious: assert property (ss_reply_valid |-> $past(ss_valid))
      else $error("start-split reply without request");
   chk_cs_answer: assert property (cs_valid |=> cs_reply_valid)
      else $error("complete-split not answered next cycle");
   chk_bulk_no_per: assert property (ds_start |-> !per_waiting && !per_take)
      else $error("bulk started while periodic work waits");
   chk_per_first: assert property (ds_done && per_waiting |-> ##[0:2] per_take)
      else $error("periodic work not taken after transaction");
   chk_adv_tick: assert property (uframe_tick |=> per_advance)
      else $error("pipeline not advanced by microframe tick");
   chk_frame_eight: assert property (frame_start |-> ticks == 4'h8)
      else $error("frame start not on eighth microframe");
   chk_tick_bound: assert property (uframe_tick |-> ticks < 4'h8)
      else $error("frame start missed");
   chk_pend_held: assert property (ds_start |=> buf_pending[ds_buf])
      else $error("started buffer not pending");
   chk_nak_still: assert property (ss_reply_valid && ss_reply == split_tt_pkg::REP_NAK
                                   && !$past(ds_done) |-> $stable(buf_pending))
      else $error("refused start-split changed buffers");
   chk_frame_time: assert property (ds_start |-> seen || frame_start)
      else $error("bulk started without frame time");
   cover property (ss_reply_valid && ss_reply == split_tt_pkg::REP_NAK);
   cover property (ds_start);
   cover property (cs_reply_valid && cs_reply == split_tt_pkg::REP_RESULT);
endmodule // split_tt_props
bind split_translator_nonperiodic_sched split_tt_props #(.NUM_BUFS(NUM_BUFS)) u_props
(
   .clk            (clk),
   .rst_n          (rst_n),
   .uframe_tick    (uframe_tick),
   .ss_valid       (ss_valid),
   .ss_reply_valid (ss_reply_valid),
   .ss_reply       (ss_reply),
   .cs_valid       (cs_valid),
   .cs_reply_valid (cs_reply_valid),
   .cs_reply       (cs_reply),
   .per_waiting    (per_waiting),
   .per_take       (per_take),
   .per_advance    (per_advance),
   .ds_start       (ds_start),
   .ds_buf         (ds_buf),
   .ds_done        (ds_done),
   .buf_pending    (buf_pending),
   .frame_start    (frame_start)
);
